/* src/busy_flag.sv */
`timescale 1ns/1ns
module busy_flag
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic set,
    input wire logic clear,
    output logic flag_q
);
    // set beats clear so a start in the done cycle is not lost
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            flag_q <= 1'b0;
        else if (set)
            flag_q <= 1'b1;
        else if (clear)
            flag_q <= 1'b0;
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_flag_set_wins: assert property (set |=> flag_q)
        else $error("pending flag missed a start");
    a_flag_clear: assert property (clear && !set |=> !flag_q)
        else $error("pending flag not cleared on done");
endmodule : busy_flag

/* src/ingress_pkg.sv */
package ingress_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int IDX_W = 6;
    localparam int PRIO_W = 3;
    localparam int PORTS = 3;
    localparam int CFG_W = 14;
    localparam int TBL_DEPTH = 64;
    // register indices; byte address is four times the index
    localparam logic [12:0] IDX_VLAN_STS = 13'h1810;
    localparam logic [12:0] IDX_TOS_CMD = 13'h1811;
    localparam logic [12:0] IDX_TOS_WDATA = 13'h1812;
    localparam logic [12:0] IDX_TOS_RDATA = 13'h1813;
    localparam logic [12:0] IDX_TOS_STS = 13'h1814;
    localparam logic [12:0] IDX_GLOBAL_CFG = 13'h1840;
    localparam int BYTE_SHIFT = 2;
    localparam int CMD_DIR_BIT = 7;
    localparam int CMD_IDX_LSB = 0;
    localparam int PEND_BIT = 0;
    localparam int PREC_MSB = 7;
    localparam int PREC_LSB = 5;
    localparam int DSCP_LSB = 2;
    localparam logic [CFG_W-1:0] CFG_RESET = 14'h0006;
    localparam logic [DATA_W-1:0] CNT_TEST_VALUE = 32'h7FFF_FFFC;
    localparam logic [DATA_W-1:0] CNT_CLEAR_VALUE = 32'h0000_0000;

    typedef struct packed {
        logic echo_allow;
        logic [PORTS-1:0] igmp_ports;
        logic ip_priority_select;
        logic spare;
        logic igmp_mon_en;
        logic counter_test;
        logic static_entry_priority;
        logic filter_multicast;
        logic drop_unknown;
        logic use_precedence;
        logic tag_priority_first;
        logic vlan_enable;
    } ingress_cfg_s;

    typedef struct packed {
        logic valid;
        logic is_unicast;
        logic is_multicast;
        logic is_broadcast;
        logic da_found;
        logic da_static;
        logic [PRIO_W-1:0] da_prio;
        logic has_tag;
        logic [PRIO_W-1:0] tag_prio;
        logic is_ipv4;
        logic is_ipv6;
        logic is_igmp;
        logic [7:0] tos;
        logic [PORTS-1:0] src_map;
        logic [PORTS-1:0] dest_map;
        logic [PRIO_W-1:0] port_prio;
    } pkt_info_s;

    typedef struct packed {
        logic valid;
        logic drop;
        logic [PORTS-1:0] dest_map;
        logic [PRIO_W-1:0] prio;
    } decision_s;
endpackage : ingress_pkg

/* src/ingress_priority_regs.sv */
`timescale 1ns/1ns
// Behaviour
// - pending bit 0 of both command status registers set while access runs
// - writing the table command register starts a table access
// - command bits 5:0 pick the table entry
// - command bit 7: one reads, zero writes
// - table has no reset; software fills it before use
// - entries hold 3-bit priority from write data, returned in read data
// - bit 13 allows snooped packets back to source port, else never
// - bits 12:10 give the port map for IGMP packets
// - bit 7 enables IGMP detection and redirection
// - bit 9 lets IP type-of-service or class choose the queue
// - bit 6 makes clear-on-read counters load 7FFF_FFFC instead
// - bit 5 with static lookup entry takes priority from that entry
// - bit 4 drops unknown multicast, never broadcast
// - bit 3 drops unknown unicast
// - bit 2 picks precedence bits or table lookup for IPv4
// - bit 1 with VLANs enabled prefers tag priority over IP
// - bit 0 enables VLAN ingress rules and tag priority
module ingress_priority_regs
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [ingress_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [ingress_pkg::DATA_W-1:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [ingress_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic vlan_cmd_start,
    input wire logic vlan_cmd_done,
    input wire ingress_pkg::pkt_info_s pkt_in,
    output ingress_pkg::decision_s decision,
    output ingress_pkg::ingress_cfg_s cfg,
    output logic [ingress_pkg::DATA_W-1:0] cnt_read_load
);
    localparam logic [ingress_pkg::ADDR_W-1:0] A_VLAN_STS =
        ingress_pkg::ADDR_W'({ingress_pkg::IDX_VLAN_STS, 2'b00});
    localparam logic [ingress_pkg::ADDR_W-1:0] A_TOS_CMD =
        ingress_pkg::ADDR_W'({ingress_pkg::IDX_TOS_CMD, 2'b00});
    localparam logic [ingress_pkg::ADDR_W-1:0] A_TOS_WDATA =
        ingress_pkg::ADDR_W'({ingress_pkg::IDX_TOS_WDATA, 2'b00});
    localparam logic [ingress_pkg::ADDR_W-1:0] A_TOS_RDATA =
        ingress_pkg::ADDR_W'({ingress_pkg::IDX_TOS_RDATA, 2'b00});
    localparam logic [ingress_pkg::ADDR_W-1:0] A_TOS_STS =
        ingress_pkg::ADDR_W'({ingress_pkg::IDX_TOS_STS, 2'b00});
    localparam logic [ingress_pkg::ADDR_W-1:0] A_GLOBAL_CFG =
        ingress_pkg::ADDR_W'({ingress_pkg::IDX_GLOBAL_CFG, 2'b00});

    logic wait_q;
    logic [ingress_pkg::DATA_W-1:0] rdata_q;
    logic wr_go;
    logic [7:0] cmd_q;
    logic [ingress_pkg::PRIO_W-1:0] wdata_reg_q;
    ingress_pkg::ingress_cfg_s cfg_q;
    ingress_pkg::decision_s dec_q;
    ingress_pkg::decision_s dec_d;
    logic [ingress_pkg::DATA_W-1:0] cnt_load_q;
    logic tos_pending;
    logic vlan_pending;
    logic cmd_start;
    logic [ingress_pkg::PRIO_W-1:0] tbl_rdata;
    logic [ingress_pkg::PRIO_W-1:0] lookup_prio;
    logic [ingress_pkg::DATA_W-1:0] rd_mux;
    logic [ingress_pkg::CFG_W-1:0] cfg_wr;

    assign waitrequest = wait_q;
    assign readdata = rdata_q;
    assign decision = dec_q;
    assign cfg = cfg_q;
    assign cnt_read_load = cnt_load_q;

    // one wait state: the request is seen, then acknowledged on the next edge
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            wait_q <= 1'b1;
        else
            wait_q <= !((read || write) && wait_q);
    end

    assign wr_go = write && !wait_q;
    // commands during an access are dropped rather than corrupting it
    assign cmd_start = wr_go && address == A_TOS_CMD && byteenable[0] && !tos_pending;

    always_comb
    begin
        rd_mux = '0;
        if (address == A_VLAN_STS)
            rd_mux[ingress_pkg::PEND_BIT] = vlan_pending;
        else if (address == A_TOS_CMD)
            rd_mux[7:0] = cmd_q;
        else if (address == A_TOS_WDATA)
            rd_mux[ingress_pkg::PRIO_W-1:0] = wdata_reg_q;
        else if (address == A_TOS_RDATA)
            rd_mux[ingress_pkg::PRIO_W-1:0] = tbl_rdata;
        else if (address == A_TOS_STS)
            rd_mux[ingress_pkg::PEND_BIT] = tos_pending;
        else if (address == A_GLOBAL_CFG)
            rd_mux[ingress_pkg::CFG_W-1:0] = cfg_q;
        else
            rd_mux = '0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            rdata_q <= '0;
        else if (read && wait_q)
            rdata_q <= rd_mux;
    end

    // reserved bit 6 of the command register is not stored
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            cmd_q <= '0;
        else if (cmd_start)
        begin
            cmd_q[ingress_pkg::CMD_DIR_BIT] <= writedata[ingress_pkg::CMD_DIR_BIT];
            cmd_q[ingress_pkg::IDX_W-1:0] <= writedata[ingress_pkg::IDX_W-1:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            wdata_reg_q <= '0;
        else if (wr_go && address == A_TOS_WDATA && byteenable[0])
            wdata_reg_q <= writedata[ingress_pkg::PRIO_W-1:0];
    end

    always_comb
    begin
        cfg_wr = cfg_q;
        if (byteenable[0])
            cfg_wr[7:0] = writedata[7:0];
        if (byteenable[1])
            cfg_wr[ingress_pkg::CFG_W-1:8] = writedata[ingress_pkg::CFG_W-1:8];
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            cfg_q <= ingress_pkg::CFG_RESET;
        else if (wr_go && address == A_GLOBAL_CFG)
            cfg_q <= cfg_wr;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            cnt_load_q <= ingress_pkg::CNT_CLEAR_VALUE;
        else if (cfg_q.counter_test)
            cnt_load_q <= ingress_pkg::CNT_TEST_VALUE;
        else
            cnt_load_q <= ingress_pkg::CNT_CLEAR_VALUE;
    end

    tos_table u_table
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(cmd_start),
        .dir_read(writedata[ingress_pkg::CMD_DIR_BIT]),
        .index(writedata[ingress_pkg::CMD_IDX_LSB +: ingress_pkg::IDX_W]),
        .wdata(wdata_reg_q),
        .lookup_idx(pkt_in.tos[ingress_pkg::PREC_MSB:ingress_pkg::DSCP_LSB]),
        .lookup_prio(lookup_prio),
        .pending(tos_pending),
        .rdata_q(tbl_rdata)
    );

    busy_flag u_vlan_busy
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .set(vlan_cmd_start),
        .clear(vlan_cmd_done),
        .flag_q(vlan_pending)
    );

    logic ip_ok;
    logic tag_ok;
    logic igmp_hit;
    logic static_hit;
    logic [ingress_pkg::PRIO_W-1:0] ip_prio;

    always_comb
    begin
        ip_ok = cfg_q.ip_priority_select && (pkt_in.is_ipv4 || pkt_in.is_ipv6);
        tag_ok = cfg_q.vlan_enable && pkt_in.has_tag;
        igmp_hit = cfg_q.igmp_mon_en && pkt_in.is_ipv4 && pkt_in.is_igmp;
        static_hit = cfg_q.static_entry_priority && pkt_in.da_found && pkt_in.da_static;
        if (pkt_in.is_ipv4 && cfg_q.use_precedence)
            ip_prio = pkt_in.tos[ingress_pkg::PREC_MSB:ingress_pkg::PREC_LSB];
        else
            ip_prio = lookup_prio;
        dec_d.valid = pkt_in.valid;
        dec_d.drop = (cfg_q.drop_unknown && pkt_in.is_unicast && !pkt_in.da_found)
            || (cfg_q.filter_multicast && pkt_in.is_multicast && !pkt_in.is_broadcast
            && !pkt_in.da_found);
        if (igmp_hit)
            dec_d.dest_map = cfg_q.igmp_ports;
        else
            dec_d.dest_map = pkt_in.dest_map;
        if (!(igmp_hit && cfg_q.echo_allow))
            dec_d.dest_map = dec_d.dest_map & ~pkt_in.src_map;
        if (static_hit)
            dec_d.prio = pkt_in.da_prio;
        else if (tag_ok && (cfg_q.tag_priority_first || !ip_ok))
            dec_d.prio = pkt_in.tag_prio;
        else if (ip_ok)
            dec_d.prio = ip_prio;
        else
            dec_d.prio = pkt_in.port_prio;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            dec_q <= '0;
        else
            dec_q <= dec_d;
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_cmd_accept;
        cmd_start;
    endsequence
    sequence s_busy_then_done;
        tos_pending ##1 !tos_pending;
    endsequence
    sequence s_read_taken;
        read && wait_q;
    endsequence

    a_cmd_pending: assert property (s_cmd_accept |=> s_busy_then_done)
        else $error("table command pending not shown then cleared");

    a_bus_one_wait: assert property ((read || write) && wait_q |=> !wait_q ##1 wait_q)
        else $error("bus answer not after exactly one wait");

    a_read_data: assert property (s_read_taken |=> !waitrequest && readdata == $past(rd_mux))
        else $error("read data not standing at the answer");

    // status is registered when the read is taken, so compare with that cycle
    a_status_read: assert property (read && wait_q && address == A_TOS_STS
        |=> rdata_q == 32'($past(tos_pending)))
        else $error("status read does not show pending");

    a_vlan_status: assert property (read && wait_q && address == A_VLAN_STS
        |=> rdata_q == 32'($past(vlan_pending)))
        else $error("vlan status read does not show pending");

    a_cmd_masked: assert property (wr_go && address == A_TOS_CMD && !byteenable[0]
        |=> !tos_pending)
        else $error("command started with its low byte disabled");

    a_cmd_index: assert property (cmd_start
        |=> cmd_q[ingress_pkg::IDX_W-1:0] == $past(writedata[ingress_pkg::IDX_W-1:0]))
        else $error("command index not captured");

    a_cmd_dir: assert property (cmd_start
        |=> cmd_q[ingress_pkg::CMD_DIR_BIT] == $past(writedata[ingress_pkg::CMD_DIR_BIT]))
        else $error("command direction not captured");

    a_wdata_load: assert property (wr_go && address == A_TOS_WDATA && byteenable[0]
        |=> wdata_reg_q == $past(writedata[ingress_pkg::PRIO_W-1:0]))
        else $error("write data register not loaded");

    a_drop_unicast: assert property (pkt_in.valid && cfg_q.drop_unknown && pkt_in.is_unicast
        && !pkt_in.da_found |=> dec_q.valid && dec_q.drop)
        else $error("unknown unicast not dropped");

    a_mcast_drop: assert property (pkt_in.valid && cfg_q.filter_multicast && pkt_in.is_multicast
        && !pkt_in.is_broadcast && !pkt_in.da_found |=> dec_q.drop)
        else $error("unknown multicast not dropped");

    a_bcast_kept: assert property (pkt_in.valid && pkt_in.is_broadcast && !pkt_in.is_unicast
        |=> !dec_q.drop)
        else $error("broadcast dropped");

    a_echo_block: assert property (pkt_in.valid && !cfg_q.echo_allow
        |=> (dec_q.dest_map & $past(pkt_in.src_map)) == '0)
        else $error("packet sent back to its source");

    a_igmp_route: assert property (pkt_in.valid && cfg_q.igmp_mon_en && pkt_in.is_ipv4 && pkt_in.is_igmp
        && cfg_q.echo_allow |=> dec_q.dest_map == $past(cfg_q.igmp_ports))
        else $error("IGMP packet not sent to monitor ports");

    a_igmp_trim: assert property (pkt_in.valid && igmp_hit && !cfg_q.echo_allow
        |=> dec_q.dest_map == $past(cfg_q.igmp_ports & ~pkt_in.src_map))
        else $error("IGMP map not trimmed of source");

    a_igmp_off: assert property (pkt_in.valid && !cfg_q.igmp_mon_en
        |=> dec_q.dest_map == $past(pkt_in.dest_map & ~pkt_in.src_map))
        else $error("packet redirected with monitoring off");

    a_static_prio: assert property (pkt_in.valid && static_hit
        |=> dec_q.prio == $past(pkt_in.da_prio))
        else $error("static entry priority not used");

    a_tag_first: assert property (pkt_in.valid && !static_hit && tag_ok && cfg_q.tag_priority_first
        |=> dec_q.prio == $past(pkt_in.tag_prio))
        else $error("tag priority not preferred");

    a_ip_first: assert property (pkt_in.valid && !static_hit && tag_ok && ip_ok
        && !cfg_q.tag_priority_first |=> dec_q.prio == $past(ip_prio))
        else $error("IP priority not preferred");

    a_tag_alone: assert property (pkt_in.valid && !static_hit && tag_ok && !ip_ok
        |=> dec_q.prio == $past(pkt_in.tag_prio))
        else $error("tag priority not used");

    a_tag_off: assert property (pkt_in.valid && !static_hit && !cfg_q.vlan_enable && !ip_ok
        |=> dec_q.prio == $past(pkt_in.port_prio))
        else $error("tag priority used with VLANs off");

    a_ip_off: assert property (pkt_in.valid && !static_hit && !tag_ok && !cfg_q.ip_priority_select
        |=> dec_q.prio == $past(pkt_in.port_prio))
        else $error("IP priority used while disabled");

    a_prec_select: assert property (pkt_in.valid && cfg_q.use_precedence && cfg_q.ip_priority_select
        && pkt_in.is_ipv4 && !pkt_in.has_tag && !cfg_q.static_entry_priority
        |=> dec_q.prio == $past(pkt_in.tos[ingress_pkg::PREC_MSB:ingress_pkg::PREC_LSB]))
        else $error("precedence bits not used");

    a_table_prio: assert property (pkt_in.valid && !static_hit && !tag_ok && ip_ok
        && !cfg_q.use_precedence |=> dec_q.prio == $past(lookup_prio))
        else $error("table priority not used");

    a_counter_value: assert property ($rose(cfg_q.counter_test)
        |=> cnt_load_q == ingress_pkg::CNT_TEST_VALUE)
        else $error("counter test load value wrong");

    a_counter_clear: assert property ($fell(cfg_q.counter_test)
        |=> cnt_load_q == ingress_pkg::CNT_CLEAR_VALUE)
        else $error("counter load not back to clear");

    a_busy_ignore: assert property (tos_pending && wr_go && address == A_TOS_CMD |=> $stable(cmd_q))
        else $error("command taken during access");
endmodule : ingress_priority_regs

/* src/tos_table.sv */
`timescale 1ns/1ns
module tos_table
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic dir_read,
    input wire logic [ingress_pkg::IDX_W-1:0] index,
    input wire logic [ingress_pkg::PRIO_W-1:0] wdata,
    input wire logic [ingress_pkg::IDX_W-1:0] lookup_idx,
    output logic [ingress_pkg::PRIO_W-1:0] lookup_prio,
    output logic pending,
    output logic [ingress_pkg::PRIO_W-1:0] rdata_q
);
    typedef enum logic {ST_IDLE, ST_BUSY} tbl_state_e;
    tbl_state_e state_q;
    logic dir_q;
    logic [ingress_pkg::IDX_W-1:0] idx_q;
    logic [ingress_pkg::PRIO_W-1:0] wdata_q;
    // no reset on the array: contents are unknown after power-up
    logic [ingress_pkg::PRIO_W-1:0] mem [ingress_pkg::TBL_DEPTH];

    assign pending = (state_q == ST_BUSY);
    assign lookup_prio = mem[lookup_idx];

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            state_q <= ST_IDLE;
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (start)
                        state_q <= ST_BUSY;
                end
                ST_BUSY:
                    state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            dir_q <= 1'b0;
            idx_q <= '0;
            wdata_q <= '0;
        end
        else if (start && state_q == ST_IDLE)
        begin
            dir_q <= dir_read;
            idx_q <= index;
            wdata_q <= wdata;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (state_q == ST_BUSY && !dir_q)
            mem[idx_q] <= wdata_q;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            rdata_q <= '0;
        else if (state_q == ST_BUSY && dir_q)
            rdata_q <= mem[idx_q];
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_write_stores: assert property (state_q == ST_BUSY && !dir_q |=> mem[idx_q] == wdata_q)
        else $error("table write did not store the entry");
    a_read_returns: assert property (state_q == ST_BUSY && dir_q |=> rdata_q == mem[idx_q])
        else $error("table read returned wrong entry");
endmodule : tos_table

/* verification/switch_ingress_priority_config_tb.sv */
`timescale 1ns/1ns
module switch_ingress_priority_config_tb;
    localparam logic [15:0] a_vlan = 16'(ingress_pkg::IDX_VLAN_STS) << ingress_pkg::BYTE_SHIFT;
    localparam logic [15:0] a_cmd = 16'(ingress_pkg::IDX_TOS_CMD) << ingress_pkg::BYTE_SHIFT;
    localparam logic [15:0] a_wdat = 16'(ingress_pkg::IDX_TOS_WDATA) << ingress_pkg::BYTE_SHIFT;
    localparam logic [15:0] a_rdat = 16'(ingress_pkg::IDX_TOS_RDATA) << ingress_pkg::BYTE_SHIFT;
    localparam logic [15:0] a_sts = 16'(ingress_pkg::IDX_TOS_STS) << ingress_pkg::BYTE_SHIFT;
    localparam logic [15:0] a_cfg = 16'(ingress_pkg::IDX_GLOBAL_CFG) << ingress_pkg::BYTE_SHIFT;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = '0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] readdata;
    logic waitrequest;
    logic vlan_cmd_start = 1'b0;
    logic vlan_cmd_done = 1'b0;
    ingress_pkg::pkt_info_s pkt_in = '0;
    ingress_pkg::decision_s decision;
    ingress_pkg::ingress_cfg_s cfg;
    logic [31:0] cnt_read_load;
    integer seed = 32'h71af;
    integer fail_count = 0;
    integer n_compared = 0;
    integer cycles = 0;
    logic [2:0] tbl [0:63];
    always #20 sys_clk = ~sys_clk;
    ingress_priority_regs uut (.sys_clk(sys_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .vlan_cmd_start(vlan_cmd_start), .vlan_cmd_done(vlan_cmd_done), .pkt_in(pkt_in),
        .decision(decision), .cfg(cfg), .cnt_read_load(cnt_read_load));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic we, input logic [15:0] a, input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] rd);
        integer n;
        n = 0;
        @(posedge sys_clk);
        address <= a;
        read <= ~we;
        write <= we;
        writedata <= d;
        byteenable <= be;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        if (n >= 50)
            check("bus answer", 32'h0, 32'h1);
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic rd_chk(input string name, input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, 4'hF, v);
        check(name, v, exp);
    endtask : rd_chk
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] v;
        bus(1'b1, a, d, be, v);
    endtask : wr
    // pending is short, so polling normally sees it clear at once
    task automatic wait_idle();
        logic [31:0] v;
        integer n;
        n = 0;
        do
        begin
            bus(1'b0, a_sts, 32'h0, 4'hF, v);
            n++;
        end
        while (v[0] !== 1'b0 && n < 20);
        check("tos pending", v, 32'h0);
    endtask : wait_idle
    function automatic ingress_pkg::decision_s expect_dec(input ingress_pkg::ingress_cfg_s c,
                                                          input ingress_pkg::pkt_info_s p);
        ingress_pkg::decision_s d;
        logic ip;
        logic igmp;
        d = '0;
        d.valid = p.valid;
        ip = c.ip_priority_select && (p.is_ipv4 || p.is_ipv6);
        if (c.static_entry_priority && p.da_found && p.da_static)
            d.prio = p.da_prio;
        else if (c.vlan_enable && p.has_tag && (c.tag_priority_first || !ip))
            d.prio = p.tag_prio;
        else if (ip && p.is_ipv4 && c.use_precedence)
            d.prio = p.tos[7:5];
        else if (ip)
            d.prio = tbl[p.tos[7:2]];
        else
            d.prio = p.port_prio;
        d.drop = !p.da_found && ((p.is_unicast && c.drop_unknown)
                 || (p.is_multicast && !p.is_broadcast && c.filter_multicast));
        igmp = c.igmp_mon_en && p.is_ipv4 && p.is_igmp;
        d.dest_map = igmp ? c.igmp_ports : p.dest_map;
        if (!(igmp && c.echo_allow))
            d.dest_map = d.dest_map & ~p.src_map;
        return d;
    endfunction : expect_dec
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    initial
    begin
        logic [13:0] cv;
        logic [31:0] v;
        logic [63:0] r;
        logic [1:0] k;
        ingress_pkg::pkt_info_s p;
        ingress_pkg::decision_s e;
        ingress_pkg::decision_s prev;
        integer j;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk("cfg reset", a_cfg, 32'h0000_0006);
        check("cfg port reset", 32'(cfg), 32'h0000_0006);
        rd_chk("vlan sts reset", a_vlan, 32'h0);
        rd_chk("unmapped", 16'h6104, 32'h0);
        $display("test reset done");
        @(posedge sys_clk);
        vlan_cmd_start <= 1'b1;
        @(posedge sys_clk);
        vlan_cmd_start <= 1'b0;
        rd_chk("vlan pending set", a_vlan, 32'h1);
        @(posedge sys_clk);
        vlan_cmd_done <= 1'b1;
        @(posedge sys_clk);
        vlan_cmd_done <= 1'b0;
        rd_chk("vlan pending clear", a_vlan, 32'h0);
        $display("test vlan pending done");
        for (int i = 0; i < 64; i++)
        begin
            tbl[i] = 3'($random(seed));
            wr(a_wdat, {29'($random(seed)), tbl[i]}, 4'hF);
            wr(a_cmd, {24'h0, 2'b00, 6'(i)}, 4'hF);
            wait_idle();
        end
        rd_chk("wdata readback", a_wdat, {29'h0, tbl[63]});
        j = 1;
        while (j < 63 && tbl[j] === tbl[0])
            j++;
        foreach (tbl[i])
        begin
            if (i == 0 || i == 63 || i == j || ($random(seed) & 3) == 0)
            begin
                wr(a_cmd, {24'h0, 2'b10, 6'(i)}, 4'hF);
                wait_idle();
                rd_chk("table read", a_rdat, {29'h0, tbl[i]});
            end
        end
        wr(a_cmd, 32'h0000_0080, 4'hF);
        wait_idle();
        // low byte disabled: command must not start, old read data stays
        wr(a_cmd, {24'h0, 2'b10, 6'(j)}, 4'hE);
        wait_idle();
        rd_chk("read data kept", a_rdat, {29'h0, tbl[0]});
        $display("test table done");
        for (int b = 0; b < 7; b++)
        begin
            cv = (b == 0) ? 14'h0006 : (b == 1) ? 14'h3FFF : (b == 2) ? 14'h0000 : 14'($random(seed));
            wr(a_cfg, {18'($random(seed)), cv}, 4'hF);
            rd_chk("cfg readback", a_cfg, {18'h0, cv});
            check("cfg port", 32'(cfg), {18'h0, cv});
            check("counter load", cnt_read_load, cv[6] ? 32'h7FFF_FFFC : 32'h0);
            prev = '0;
            for (int i = 0; i <= 120; i++)
            begin
                r = {$random(seed), $random(seed)};
                p = r[$bits(ingress_pkg::pkt_info_s)-1:0];
                k = 2'({$random(seed)} % 3);
                p.is_unicast = (k == 2'd0);
                p.is_multicast = (k != 2'd0);
                p.is_broadcast = (k == 2'd2);
                p.da_static = p.da_static & p.da_found;
                p.is_ipv6 = p.is_ipv6 & ~p.is_ipv4;
                if (i == 120)
                    p = '0;
                @(posedge sys_clk);
                pkt_in <= p;
                @(negedge sys_clk);
                if (prev.valid === 1'b1)
                    check("decision", 32'(decision), 32'(prev));
                else
                    check("decision valid", 32'(decision.valid), 32'(prev.valid));
                prev = expect_dec(ingress_pkg::ingress_cfg_s'(cv), p);
            end
        end
        $display("test packet path done");
        report_and_stop();
    end
endmodule : switch_ingress_priority_config_tb
